// ### rtl/cph_defines.vh
// Constants for the contactless programmer host command interpreter
// Summary of operation
// - Serial link runs 9600 baud, eight data bits, one stop bit, no parity.
// - Wake-up character 0x57 prepares the block, then it replies ready 0x52.
// - Blank-check character 0x54 reads the tag, testing all ones and unlocked.
// - Blank and unlocked tag gives reply 0x59, programming may proceed.
// - Tag not blank or locked gives error reply 0x4E.
// - Sixteen bytes arrive as ASCII hex digit pairs; each character is echoed.
// - A 96-bit tag still takes all sixteen bytes; bits 33-64 ignored.
// - Character 0x56 after sixteen bytes programs the tag and then verifies.
// - Verify success replies 0x79, failure replies 0x6E.
// - No character for over 3 seconds abandons the sequence and resets; the code keeps the timer at zero during blank check and programming.
// - Invalid data during loading returns an invalid-data indication.
// - Invalid-data reply is 0x49; afterwards restart from wake-up.
`ifndef CPH_DEFINES_VH
`define CPH_DEFINES_VH

`define CPH_CLK_HZ        100000000
`define CPH_BAUD          9600
`define CPH_BIT_CYC       ((`CPH_CLK_HZ + `CPH_BAUD / 2) / `CPH_BAUD)
`define CPH_TIMEOUT_S     3
`define CPH_TIMEOUT_CYC   (`CPH_TIMEOUT_S * `CPH_CLK_HZ)
`define CPH_DATA_BYTES    16
`define CPH_DATA_CHARS    (2 * `CPH_DATA_BYTES)

`define CPH_CH_WAKE       8'h57
`define CPH_CH_READY      8'h52
`define CPH_CH_BLANK      8'h54
`define CPH_CH_BLANK_OK   8'h59
`define CPH_CH_BLANK_BAD  8'h4e
`define CPH_CH_PROG       8'h56
`define CPH_CH_PROG_OK    8'h79
`define CPH_CH_PROG_BAD   8'h6e
`define CPH_CH_INVALID    8'h49
`define CPH_CH_ZERO       8'h30
`define CPH_CH_NINE       8'h39
`define CPH_CH_UP_A       8'h41
`define CPH_CH_UP_F       8'h46

`define CPH_TX_FIFO_DEPTH 8

`endif

// ### rtl/cph_fifo.v
// Synchronous valid/ready FIFO for the reply path
`timescale 1ns/1ps
`default_nettype none
module cph_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             mclk_i,
	input  wire             sys_rst_i,
	// Fill side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// Drain side
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_r;
	reg [AW-1:0]    rd_ptr_r;
	reg [AW:0]      count_r;
	wire            push;
	wire            pop;

	assign in_ready_o  = (count_r != DEPTH[AW:0]);
	assign out_valid_o = (count_r != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr_r];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge mclk_i) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data_i;
		end
	end

	always @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			if (push & ~pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop & ~push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // cph_fifo
`default_nettype wire

// ### rtl/cph_host_cmd.v
// Serial command interpreter of the contactless tag programmer
`timescale 1ns/1ps
`default_nettype none
`include "cph_defines.vh"
module cph_host_cmd #(
	parameter BIT_CYC     = `CPH_BIT_CYC,
	parameter TIMEOUT_CYC = `CPH_TIMEOUT_CYC
) (
	// Clock and reset
	input  wire         mclk_i,
	input  wire         sys_rst_i,
	// Serial link
	input  wire         ser_rx_i,
	output reg          ser_tx_o,
	// Blank check towards the tag front end
	output reg          blank_req_o,
	input  wire         blank_done_i,
	input  wire         tag_blank_i,
	input  wire         tag_unlocked_i,
	// Program and verify towards the tag front end
	output reg          prog_req_o,
	output reg  [127:0] prog_data_o,
	input  wire         prog_done_i,
	input  wire         prog_ok_i,
	// Status
	output wire         awake_o
);
	localparam ST_IDLE  = 3'd0;
	localparam ST_READY = 3'd1;
	localparam ST_BLANK = 3'd2;
	localparam ST_LOAD  = 3'd3;
	localparam ST_WAITV = 3'd4;
	localparam ST_PROG  = 3'd5;

	localparam RX_IDLE  = 2'd0;
	localparam RX_START = 2'd1;
	localparam RX_DATA  = 2'd2;
	localparam RX_STOP  = 2'd3;

	// Receiver: pin passes two flops before use
	reg        rx_meta_r;
	reg        rx_sync_r;
	reg [1:0]  rx_st_r;
	reg [31:0] rx_cnt_r;
	reg [2:0]  rx_bit_r;
	reg [7:0]  rx_shift_r;
	reg        rx_stb_r;
	reg [7:0]  rx_byte_r;

	always @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_meta_r  <= 1'b1;
			rx_sync_r  <= 1'b1;
			rx_st_r    <= RX_IDLE;
			rx_cnt_r   <= 32'h0;
			rx_bit_r   <= 3'h0;
			rx_shift_r <= 8'h00;
			rx_stb_r   <= 1'b0;
			rx_byte_r  <= 8'h00;
		end else begin
			rx_meta_r <= ser_rx_i;
			rx_sync_r <= rx_meta_r;
			rx_stb_r  <= 1'b0;
			case (rx_st_r)
			RX_IDLE: begin
				rx_cnt_r <= 32'h0;
				if (!rx_sync_r) begin
					rx_st_r <= RX_START;
				end
			end
			RX_START: begin
				// Recheck at mid-bit so a glitch is not taken as a start
				if (rx_cnt_r == BIT_CYC / 2) begin
					rx_cnt_r <= 32'h0;
					rx_bit_r <= 3'h0;
					rx_st_r  <= rx_sync_r ? RX_IDLE : RX_DATA;
				end else begin
					rx_cnt_r <= rx_cnt_r + 32'h1;
				end
			end
			RX_DATA: begin
				if (rx_cnt_r == BIT_CYC - 1) begin
					rx_cnt_r   <= 32'h0;
					rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};
					rx_bit_r   <= rx_bit_r + 3'h1;
					if (rx_bit_r == 3'h7) begin
						rx_st_r <= RX_STOP;
					end
				end else begin
					rx_cnt_r <= rx_cnt_r + 32'h1;
				end
			end
			default: begin
				if (rx_cnt_r == BIT_CYC - 1) begin
					rx_st_r <= RX_IDLE;
					// A low stop bit is a framing error; the character is dropped
					if (rx_sync_r) begin
						rx_stb_r  <= 1'b1;
						rx_byte_r <= rx_shift_r;
					end
				end else begin
					rx_cnt_r <= rx_cnt_r + 32'h1;
				end
			end
			endcase
		end
	end

	// Reply path: one pending character, then the FIFO, then the transmitter
	reg        rep_vld_r;
	reg [7:0]  rep_chr_r;
	wire       fifo_in_rdy;
	wire       fifo_out_vld;
	wire [7:0] fifo_out_data;
	reg        tx_busy_r;
	wire       tx_take;

	assign tx_take = fifo_out_vld & ~tx_busy_r;

	cph_fifo #(
		.WIDTH (8),
		.DEPTH (`CPH_TX_FIFO_DEPTH),
		.AW    (3)
	) u_tx_fifo (
		.mclk_i      (mclk_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (rep_vld_r),
		.in_ready_o  (fifo_in_rdy),
		.in_data_i   (rep_chr_r),
		.out_valid_o (fifo_out_vld),
		.out_ready_i (tx_take),
		.out_data_o  (fifo_out_data)
	);

	// Transmitter: start, eight data bits LSB first, stop
	reg [8:0]  tx_shift_r;
	reg [3:0]  tx_bit_r;
	reg [31:0] tx_cnt_r;

	always @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ser_tx_o   <= 1'b1;
			tx_busy_r  <= 1'b0;
			tx_shift_r <= 9'h1ff;
			tx_bit_r   <= 4'h0;
			tx_cnt_r   <= 32'h0;
		end else if (tx_take) begin
			tx_busy_r  <= 1'b1;
			ser_tx_o   <= 1'b0;
			tx_shift_r <= {1'b1, fifo_out_data};
			tx_bit_r   <= 4'h0;
			tx_cnt_r   <= 32'h0;
		end else if (tx_busy_r) begin
			if (tx_cnt_r == BIT_CYC - 1) begin
				tx_cnt_r <= 32'h0;
				if (tx_bit_r == 4'h9) begin
					tx_busy_r <= 1'b0;
				end else begin
					ser_tx_o   <= tx_shift_r[0];
					tx_shift_r <= {1'b1, tx_shift_r[8:1]};
					tx_bit_r   <= tx_bit_r + 4'h1;
				end
			end else begin
				tx_cnt_r <= tx_cnt_r + 32'h1;
			end
		end
	end

	// Command state machine
	reg [2:0]  st_r;
	reg [5:0]  nchar_r;
	reg [31:0] idle_cnt_r;
	reg [3:0]  nib;
	reg        nib_ok;
	wire       op_busy;
	wire       timed_out;

	assign awake_o   = (st_r != ST_IDLE);
	assign op_busy   = (st_r == ST_BLANK) | (st_r == ST_PROG);
	// The long tag operations hold the timer; the host is waiting then
	assign timed_out = (idle_cnt_r >= TIMEOUT_CYC) & awake_o & ~op_busy;

	always @* begin
		nib    = 4'h0;
		nib_ok = 1'b0;
		if (rx_byte_r >= `CPH_CH_ZERO && rx_byte_r <= `CPH_CH_NINE) begin
			nib    = rx_byte_r[3:0];
			nib_ok = 1'b1;
		end else if (rx_byte_r >= `CPH_CH_UP_A && rx_byte_r <= `CPH_CH_UP_F) begin
			nib    = rx_byte_r[3:0] + 4'h9;
			nib_ok = 1'b1;
		end
	end

	always @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r        <= ST_IDLE;
			nchar_r     <= 6'h0;
			idle_cnt_r  <= 32'h0;
			rep_vld_r   <= 1'b0;
			rep_chr_r   <= 8'h00;
			blank_req_o <= 1'b0;
			prog_req_o  <= 1'b0;
			prog_data_o <= 128'h0;
		end else begin
			blank_req_o <= 1'b0;
			prog_req_o  <= 1'b0;
			if (rep_vld_r & fifo_in_rdy) begin
				rep_vld_r <= 1'b0;
			end
			if (rx_stb_r | op_busy) begin
				idle_cnt_r <= 32'h0;
			end else if (!timed_out) begin
				idle_cnt_r <= idle_cnt_r + 32'h1;
			end
			if (timed_out) begin
				st_r <= ST_IDLE;
			end else if (rep_vld_r) begin
				// Full reply path stalls command handling until the reply is queued
				st_r <= st_r;
			end else begin
				case (st_r)
				ST_BLANK: begin
					if (blank_done_i) begin
						rep_vld_r <= 1'b1;
						if (tag_blank_i & tag_unlocked_i) begin
							rep_chr_r <= `CPH_CH_BLANK_OK;
							nchar_r   <= 6'h0;
							st_r      <= ST_LOAD;
						end else begin
							rep_chr_r <= `CPH_CH_BLANK_BAD;
							st_r      <= ST_READY;
						end
					end
				end
				ST_PROG: begin
					if (prog_done_i) begin
						rep_vld_r <= 1'b1;
						rep_chr_r <= prog_ok_i ? `CPH_CH_PROG_OK : `CPH_CH_PROG_BAD;
						st_r      <= ST_READY;
					end
				end
				default: begin
					if (rx_stb_r) begin
						if (rx_byte_r == `CPH_CH_WAKE && st_r != ST_LOAD) begin
							rep_vld_r <= 1'b1;
							rep_chr_r <= `CPH_CH_READY;
							st_r      <= ST_READY;
						end else if (st_r == ST_READY && rx_byte_r == `CPH_CH_BLANK) begin
							blank_req_o <= 1'b1;
							st_r        <= ST_BLANK;
						end else if (st_r == ST_LOAD) begin
							rep_vld_r <= 1'b1;
							if (nib_ok) begin
								rep_chr_r   <= rx_byte_r;
								// All 32 digits kept; a 96-bit tag ignores its own bits
								prog_data_o <= {prog_data_o[123:0], nib};
								nchar_r     <= nchar_r + 6'h1;
								if (nchar_r == `CPH_DATA_CHARS - 1) begin
									st_r <= ST_WAITV;
								end
							end else begin
								rep_chr_r <= `CPH_CH_INVALID;
								st_r      <= ST_IDLE;
							end
						end else if (st_r == ST_WAITV && rx_byte_r == `CPH_CH_PROG) begin
							prog_req_o <= 1'b1;
							st_r       <= ST_PROG;
						end
					end
				end
				endcase
			end
		end
	end
endmodule // cph_host_cmd
`default_nettype wire

// ### testbench/cph_host_cmd_assertions.sv
// Port checker for the host command interpreter
`timescale 1ns/1ps
`default_nettype none
module cph_host_cmd_assertions #(
	parameter BIT_CYC     = 16,
	parameter TIMEOUT_CYC = 2000
) (
	// Clock and reset
	input wire logic         mclk_i,
	input wire logic         sys_rst_i,
	// Serial link
	input wire logic         ser_rx_i,
	input wire logic         ser_tx_o,
	// Tag front end
	input wire logic         blank_req_o,
	input wire logic         blank_done_i,
	input wire logic         tag_blank_i,
	input wire logic         tag_unlocked_i,
	input wire logic         prog_req_o,
	input wire logic [127:0] prog_data_o,
	input wire logic         prog_done_i,
	input wire logic         prog_ok_i,
	// Status
	input wire logic         awake_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	property p_blank_pulse;
		blank_req_o |=> !blank_req_o [*8];
	endproperty
	a_blank_pulse: assert property (p_blank_pulse) else $error("blank req repeat");
	property p_prog_pulse;
		prog_req_o |=> (!prog_req_o && !blank_req_o) [*8];
	endproperty
	a_prog_pulse: assert property (p_prog_pulse) else $error("prog req repeat");
	property p_excl;
		!(blank_req_o && prog_req_o);
	endproperty
	a_excl: assert property (p_excl) else $error("two requests");
	property p_blank_awake;
		blank_req_o |-> awake_o;
	endproperty
	a_blank_awake: assert property (p_blank_awake) else $error("blank req asleep");
	property p_prog_awake;
		prog_req_o |-> awake_o && $past(awake_o, 8);
	endproperty
	a_prog_awake: assert property (p_prog_awake) else $error("prog req asleep");
	property p_data_stable;
		prog_req_o |-> $stable(prog_data_o);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("data moved");
	// A short start bit means the baud divider is wrong
	property p_tx_start;
		$fell(ser_tx_o) |=> !ser_tx_o [*6];
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("short start bit");
	property p_req_after_stop;
		(blank_req_o || prog_req_o) |-> ser_rx_i && $past(ser_rx_i, 3);
	endproperty
	a_req_after_stop: assert property (p_req_after_stop) else $error("req mid char");
	c_blank: cover property (blank_req_o);
	c_prog: cover property (prog_req_o);
	c_sleep: cover property ($fell(awake_o));
endmodule // cph_host_cmd_assertions
bind cph_host_cmd cph_host_cmd_assertions #(
	.BIT_CYC     (BIT_CYC),
	.TIMEOUT_CYC (TIMEOUT_CYC)
) cph_host_cmd_assertions_i (
	.mclk_i, .sys_rst_i, .ser_rx_i, .ser_tx_o, .blank_req_o, .blank_done_i,
	.tag_blank_i, .tag_unlocked_i, .prog_req_o, .prog_data_o, .prog_done_i,
	.prog_ok_i, .awake_o
);
`default_nettype wire

// ### testbench/cph_host_model.sv
// Host side serial model: sends and receives 8N1 characters
`timescale 1ns/1ps
`default_nettype none
module cph_host_model #(
	parameter BIT_CYC = 16
) (
	input  wire logic mclk_i,
	input  wire logic line_i,
	output var  logic line_o
);
	logic [7:0] got_r;
	int         n_rx;
	initial line_o = 1'b1;
	initial n_rx = 0;
	// Start, eight bits LSB first, one stop, no parity
	task automatic send(input logic [7:0] c, input logic stp = 1'b1);
		logic [9:0] f;
		f = {stp, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge mclk_i) line_o <= f[i];
			repeat (BIT_CYC - 1) @(posedge mclk_i);
		end
		// A low stop bit leaves the line low; lift it so the next start is seen
		if (!stp) begin
			@(posedge mclk_i) line_o <= 1'b1;
			repeat (BIT_CYC - 1) @(posedge mclk_i);
		end
	endtask
	always begin
		@(negedge line_i);
		repeat (BIT_CYC / 2) @(posedge mclk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge mclk_i);
			got_r[i] = line_i;
		end
		repeat (BIT_CYC) @(posedge mclk_i);
		n_rx++;
	end
endmodule // cph_host_model
`default_nettype wire

// ### testbench/cph_host_cmd_tb.sv
// Self-checking bench for the host command interpreter
`timescale 1ns/1ps
`default_nettype none
module cph_host_cmd_tb;
	localparam int BC = 16;
	localparam int TO = 2000;
	logic         mclk_i = 1'b0;
	logic         sys_rst_i = 1'b1;
	logic         ser_rx_i, ser_tx_o, blank_req_o, prog_req_o, awake_o;
	logic         blank_done_i = 1'b0, tag_blank_i = 1'b0, tag_unlocked_i = 1'b0;
	logic         prog_done_i = 1'b0, prog_ok_i = 1'b0;
	logic [127:0] prog_data_o;
	int           n_errors = 0, checked = 0, cyc = 0, w, lat = 0, wt = 0;
	string        hx = "0123456789ABCDEF";
	// Row: sent char, reply, tag blank, unlocked, verify ok; 00 loads data
	logic [18:0]  rows [10] = '{{8'h57, 8'h52, 3'b000}, {8'h54, 8'h4e, 3'b010},
		{8'h54, 8'h4e, 3'b100}, {8'h54, 8'h59, 3'b110}, {8'h00, 8'h00, 3'b110},
		{8'h56, 8'h79, 3'b111}, {8'h57, 8'h52, 3'b110}, {8'h54, 8'h59, 3'b110},
		{8'h00, 8'h00, 3'b110}, {8'h56, 8'h6e, 3'b110}};
	cph_host_cmd #(.BIT_CYC(BC), .TIMEOUT_CYC(TO)) cph_host_cmd_i (
		.mclk_i, .sys_rst_i, .ser_rx_i, .ser_tx_o, .blank_req_o, .blank_done_i,
		.tag_blank_i, .tag_unlocked_i, .prog_req_o, .prog_data_o, .prog_done_i,
		.prog_ok_i, .awake_o);
	cph_host_model #(.BIT_CYC(BC)) cph_host_model_i (
		.mclk_i, .line_i(ser_tx_o), .line_o(ser_rx_i));
	always #5 mclk_i = ~mclk_i;
	// Tag front end: blank check answers lat+1 cycles after the request, or one cycle when lat is 0; program after one
	always @(posedge mclk_i) begin
		blank_done_i <= (blank_req_o && lat == 0) || wt == 1;
		prog_done_i <= prog_req_o;
		if (blank_req_o) wt <= lat;
		else if (wt > 0) wt <= wt - 1;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [127:0] got, exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Host waits for each reply before the next char
	task automatic xfer(input logic [7:0] c, e);
		w = cph_host_model_i.n_rx;
		cph_host_model_i.send(c);
		for (int k = 0; k < 400 && cph_host_model_i.n_rx == w; k++) @(posedge mclk_i);
		chk("nrx", cph_host_model_i.n_rx - w, 1);
		chk("reply", cph_host_model_i.got_r, e);
	endtask
	task automatic load();
		for (int i = 0; i < 32; i++) xfer(hx[i % 16], hx[i % 16]);
		chk("data", prog_data_o, {2{64'h0123456789abcdef}});
	endtask
	task automatic tally_and_finish();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk_i);
		chk("rst", {ser_tx_o, awake_o, blank_req_o, prog_req_o, |prog_data_o}, 5'h10);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		foreach (rows[r]) begin
			{tag_blank_i, tag_unlocked_i, prog_ok_i} <= rows[r][2:0];
			if (rows[r][18:11] == 8'h00) load();
			else xfer(rows[r][18:11], rows[r][10:3]);
		end
		// Blank check outlasting the timeout: the timer must hold while the tag works
		lat = TO + 200;
		w = cph_host_model_i.n_rx;
		cph_host_model_i.send(8'h54);
		repeat (TO + 600) @(posedge mclk_i);
		lat = 0;
		chk("slow_n", cph_host_model_i.n_rx - w, 1);
		chk("slow_y", cph_host_model_i.got_r, 8'h59);
		xfer(8'h61, 8'h49);
		chk("awake_inv", awake_o, 1'b0);
		xfer(8'h57, 8'h52);
		repeat (TO - 400) @(posedge mclk_i);
		chk("awake_run", awake_o, 1'b1);
		repeat (800) @(posedge mclk_i);
		chk("awake_to", awake_o, 1'b0);
		w = cph_host_model_i.n_rx;
		cph_host_model_i.send(8'h57, 1'b0);
		chk("awake_frm", awake_o, 1'b0);
		cph_host_model_i.send(8'h54);
		repeat (300) @(posedge mclk_i);
		chk("quiet", cph_host_model_i.n_rx - w, 0);
		xfer(8'h57, 8'h52);
		// Reset in mid-run must drop the woken state and the loaded data
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		chk("rst_mid", {ser_tx_o, awake_o, blank_req_o, prog_req_o, |prog_data_o}, 5'h10);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		xfer(8'h57, 8'h52);
		tally_and_finish();
	end
endmodule // cph_host_cmd_tb
`default_nettype wire
